// file: src/sib_slave_interface_block.sv
// Behaviour
// - Unmapped or blocked address gets decode error
// - Error shown only under allowed options, unbroken
// - Write data never interleaved, master sends contiguously
// - Address 32..64 bits, data up to 256
// - User sideband width 0..256 bits
// - Secure port tags secure, reaches all
// - Non-secure port tags non-secure, blocked
// - Per-access mode follows the protNonsec input
// - Write acceptance limit one to thirty-two
// - Read acceptance limit one to 127
// - Full slice adds two, forward adds one
// - Slave variant uses select and both readies
// - Mirrored variant ignores select and ready-in
// - Word-invariant little-endian data bus
// - No broken bursts on mirrored port
// - Early response and broken bursts independent
// - Crossing mode selectable, async or ratio
// - Incrementing writes become singles, buffered response
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sib_cfg.svh"
module sib_slave_interface_block
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Register bus
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Upstream bus master port
	input wire logic hsel,
	input wire logic hreadyIn,
	input wire logic [`SIB_ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [2:0] hburst,
	input wire logic [3:0] hprot,
	input wire logic protNonsec,
	input wire logic [`SIB_USER_W-1:0] huser,
	input wire logic [`SIB_DATA_W-1:0] hwdata,
	output logic [`SIB_DATA_W-1:0] hrdata,
	output logic hreadyOut,
	output logic hresp,
	// Network side
	output logic netReqValid,
	input wire logic netReqReady,
	output logic [`SIB_ADDR_W-1:0] netAddr,
	output logic netWrite,
	output logic [2:0] netSize,
	output logic [2:0] netProt,
	output logic [`SIB_USER_W-1:0] netUser,
	output logic [`SIB_DATA_W-1:0] netWdata,
	input wire logic netRspValid,
	input wire logic netRspWrite,
	input wire logic [`SIB_DATA_W-1:0] netRspData,
	input wire logic [1:0] netRspResp,
	// Crossing selection
	output sib_pkg::sib_cdc_t cdcMode
);
	import sib_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic [31:0] ctrlReg;
	logic [6:0] wrLimit;
	logic [6:0] rdLimit;
	logic [15:0] decErrCnt;
	logic [15:0] brokenCnt;
	logic [31:0] awAddrQ;
	logic [31:0] wDataQ;
	logic [3:0] wStrbQ;
	logic awHeld;
	logic wHeld;
	logic regWr;
	logic [31:0] regRd;
	logic [1:0] rdResp;
	sib_sec_t secMode;
	sib_slice_t sliceKind;
	logic ewrEn;
	logic brokenEff;
	logic mirrored;
	logic [1:0] bonus;
	sib_state_t state;
	sib_state_t next_state;
	logic take;
	logic idleSeen;
	logic secureTag;
	logic inTgt;
	logic inGpv;
	logic inSec;
	logic decErr;
	logic [3:0] beatsLeft;
	logic [3:0] burstLen;
	logic aWrite;
	logic [3:0] aProt;
	logic aFixed;
	logic aDecErr;
	logic posted;
	logic showErr;
	logic canIssue;
	logic rspHit;
	logic errTail;
	sib_cnt_if wrCnt ();
	sib_cnt_if rdCnt ();

	// ****************************************
	// Register bus
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		merge = (old & ~m) | (d & m);
	endfunction

	function automatic logic [6:0] clampLim(input logic [6:0] v, input logic [6:0] mx);
		clampLim = (v < `SIB_LIM_MIN) ? `SIB_LIM_MIN : ((v > mx) ? mx : v);
	endfunction

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign regWr = awHeld && wHeld && !s_axi_bvalid;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrQ <= 32'h0000_0000;
			wDataQ <= 32'h0000_0000;
			wStrbQ <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld <= 1'b1;
				awAddrQ <= s_axi_awaddr;
			end
			else if (regWr)
				awHeld <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld <= 1'b1;
				wDataQ <= s_axi_wdata;
				wStrbQ <= s_axi_wstrb;
			end
			else if (regWr)
				wHeld <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SIB_RESP_OKAY;
		end
		else if (regWr)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awAddrQ[31:8] == 24'h000000 && (awAddrQ[7:0] == `SIB_REG_CTRL
				|| awAddrQ[7:0] == `SIB_REG_LIMIT)) ? `SIB_RESP_OKAY : `SIB_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Control and limit registers
	always_ff @(posedge sys_clk)
	begin
		logic [31:0] nv;
		nv = merge(ctrlReg, wDataQ, wStrbQ);
		if (srst)
		begin
			ctrlReg <= `SIB_CTRL_RST;
			wrLimit <= `SIB_LIM_WR_MAX;
			rdLimit <= `SIB_LIM_RD_MAX;
		end
		else if (regWr && awAddrQ[31:8] == 24'h000000)
		begin
			if (awAddrQ[7:0] == `SIB_REG_CTRL)
			begin
				ctrlReg <= nv;
				if (nv[`SIB_CTRL_MIR_BIT])
					ctrlReg[`SIB_CTRL_BRK_BIT] <= 1'b0;
			end
			else if (awAddrQ[7:0] == `SIB_REG_LIMIT)
			begin
				nv = merge({17'h00000, rdLimit, 1'b0, wrLimit}, wDataQ, wStrbQ);
				wrLimit <= clampLim({1'b0, nv[`SIB_LIM_WR_LSB +: 6]}, `SIB_LIM_WR_MAX);
				rdLimit <= clampLim(nv[`SIB_LIM_RD_LSB +: 7], `SIB_LIM_RD_MAX);
			end
		end
	end

	always_comb
	begin
		regRd = 32'h0000_0000;
		rdResp = `SIB_RESP_OKAY;
		if (s_axi_araddr[31:8] != 24'h000000)
			rdResp = `SIB_RESP_SLVERR;
		else
			case (s_axi_araddr[7:0])
				`SIB_REG_CTRL: regRd = ctrlReg;
				`SIB_REG_LIMIT: regRd = {17'h00000, rdLimit, 1'b0, wrLimit};
				`SIB_REG_STATUS: regRd = {15'h0000, state == SIB_IDLE, rdCnt.count,
					wrCnt.count};
				`SIB_REG_ERRCNT: regRd = {brokenCnt, decErrCnt};
				default: rdResp = `SIB_RESP_SLVERR;
			endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SIB_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= regRd;
			s_axi_rresp <= rdResp;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// Configuration decode
	// ****************************************
	assign secMode = sib_sec_t'(ctrlReg[`SIB_CTRL_SEC_LSB +: 2]);
	assign sliceKind = sib_slice_t'(ctrlReg[`SIB_CTRL_SLICE_LSB +: 2]);
	assign ewrEn = ctrlReg[`SIB_CTRL_EWR_BIT];
	assign mirrored = ctrlReg[`SIB_CTRL_MIR_BIT];
	assign brokenEff = ctrlReg[`SIB_CTRL_BRK_BIT] && !mirrored;
	assign cdcMode = sib_cdc_t'(ctrlReg[`SIB_CTRL_SYNC_LSB +: 3]);

	always_comb
	begin
		case (sliceKind)
			SIB_SLICE_FULL: bonus = `SIB_SLICE_FULL_BONUS;
			SIB_SLICE_FWD: bonus = `SIB_SLICE_FWD_BONUS;
			default: bonus = 2'h0;
		endcase
	end

	// ****************************************
	// Acceptance counters
	// ****************************************
	assign wrCnt.inc = netReqValid && netReqReady && netWrite;
	assign wrCnt.dec = netRspValid && netRspWrite;
	assign wrCnt.limit = wrLimit;
	assign wrCnt.bonus = bonus;
	assign rdCnt.inc = netReqValid && netReqReady && !netWrite;
	assign rdCnt.dec = netRspValid && !netRspWrite;
	assign rdCnt.limit = rdLimit;
	assign rdCnt.bonus = bonus;

	sib_acc_cnt wrCntInst (.sys_clk(sys_clk), .srst(srst), .cif(wrCnt.cnt));
	sib_acc_cnt rdCntInst (.sys_clk(sys_clk), .srst(srst), .cif(rdCnt.cnt));

	// ****************************************
	// Address phase and decode
	// ****************************************
	// select and ready-in qualify, except in the mirrored variant
	assign take = state == SIB_IDLE && (mirrored || (hsel && hreadyIn)) && htrans[1];
	assign idleSeen = state == SIB_IDLE && (mirrored || (hsel && hreadyIn))
		&& htrans == `SIB_HTRANS_IDLE;

	always_comb
	begin
		case (secMode)
			SIB_SEC_SECURE: secureTag = 1'b1;
			SIB_SEC_NONSEC: secureTag = 1'b0;
			default: secureTag = !protNonsec;
		endcase
	end

	assign inTgt = haddr >= `SIB_TGT_BASE && haddr <= `SIB_TGT_TOP;
	assign inGpv = haddr >= `SIB_GPV_BASE && haddr <= `SIB_GPV_TOP;
	assign inSec = haddr >= `SIB_SEC_BASE && haddr <= `SIB_SEC_TOP;
	assign decErr = !(inTgt || inGpv) || (!secureTag && inSec);

	assign burstLen = (hburst[2:1] == 2'h1) ? 4'h3 : (hburst[2:1] == 2'h2) ? 4'h7
		: (hburst[2:1] == 2'h3) ? 4'hf : 4'h0;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			netAddr <= '0;
			netWrite <= 1'b0;
			netSize <= 3'h0;
			netProt <= 3'h0;
			netUser <= '0;
			aWrite <= 1'b0;
			aProt <= 4'h0;
			aFixed <= 1'b0;
			aDecErr <= 1'b0;
		end
		else if (take)
		begin
			netAddr <= haddr;
			netWrite <= hwrite;
			netSize <= hsize;
			netProt <= {!hprot[0], !secureTag, hprot[1]};
			netUser <= huser;
			aWrite <= hwrite;
			aProt <= hprot;
			aFixed <= hburst[2:1] != 2'h0;
			aDecErr <= decErr;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			netWdata <= '0;
		else if (state == SIB_DATA)
			netWdata <= hwdata;
	end

	// Burst tracking for early termination
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			beatsLeft <= 4'h0;
			brokenCnt <= 16'h0000;
		end
		else if (take && htrans == `SIB_HTRANS_NONSEQ)
		begin
			if (beatsLeft != 4'h0)
				brokenCnt <= brokenCnt + 16'h0001;
			beatsLeft <= burstLen;
		end
		else if (take && beatsLeft != 4'h0)
			beatsLeft <= beatsLeft - 4'h1;
		else if (idleSeen && beatsLeft != 4'h0)
		begin
			brokenCnt <= brokenCnt + 16'h0001;
			beatsLeft <= 4'h0;
		end
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	assign posted = aWrite && ewrEn && aProt[3];
	assign showErr = (!ewrEn || !aProt[3]) && !(brokenEff && aFixed);
	assign canIssue = aWrite ? (!wrCnt.full && (posted || wrCnt.count == 8'h00))
		: !rdCnt.full;
	assign rspHit = netRspValid && (netRspWrite == aWrite);
	assign netReqValid = state == SIB_ISSUE && canIssue;

	always_comb
	begin
		next_state = state;
		case (state)
			SIB_IDLE:
				if (take)
					next_state = SIB_DATA;
			SIB_DATA:
				if (aDecErr)
					next_state = (showErr && !posted) ? SIB_ERR1 : SIB_IDLE;
				else
					next_state = SIB_ISSUE;
			SIB_ISSUE:
				if (netReqValid && netReqReady)
					next_state = posted ? SIB_IDLE : SIB_WAIT;
			SIB_WAIT:
				if (rspHit)
					next_state = (netRspResp[1] && showErr) ? SIB_ERR1 : SIB_IDLE;
			SIB_ERR1:
				next_state = SIB_IDLE;
			default:
				next_state = SIB_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			state <= SIB_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			errTail <= 1'b0;
		else
			errTail <= state == SIB_ERR1;
	end

	assign hreadyOut = state == SIB_IDLE;
	assign hresp = state == SIB_ERR1 || (state == SIB_IDLE && errTail);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			hrdata <= '0;
		else if (state == SIB_WAIT && rspHit && !aWrite)
			hrdata <= netRspData;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			decErrCnt <= 16'h0000;
		else if ((state == SIB_DATA && aDecErr)
			|| (state == SIB_WAIT && rspHit && netRspResp == `SIB_RESP_DECERR))
			decErrCnt <= decErrCnt + 16'h0001;
	end
endmodule

// file: src/sib_cfg.svh
`ifndef SIB_CFG_SVH
`define SIB_CFG_SVH

// ****************************************
// Widths
// ****************************************
// Address 32..64, data 32/64/128/256, user sideband 0..256
`define SIB_ADDR_W 32
`define SIB_DATA_W 32
`define SIB_USER_W 8

// ****************************************
// Register offsets
// ****************************************
`define SIB_REG_CTRL 8'h00
`define SIB_REG_LIMIT 8'h04
`define SIB_REG_STATUS 8'h08
`define SIB_REG_ERRCNT 8'h0c

// ****************************************
// Field positions and reset values
// ****************************************
`define SIB_CTRL_SEC_LSB 0
`define SIB_CTRL_EWR_BIT 2
`define SIB_CTRL_BRK_BIT 3
`define SIB_CTRL_MIR_BIT 4
`define SIB_CTRL_SYNC_LSB 5
`define SIB_CTRL_SLICE_LSB 8
`define SIB_CTRL_RST 32'h0000_0000
`define SIB_LIM_WR_LSB 0
`define SIB_LIM_RD_LSB 8
`define SIB_LIM_WR_MAX 7'h20
`define SIB_LIM_RD_MAX 7'h7f
`define SIB_LIM_MIN 7'h01
`define SIB_SLICE_FULL_BONUS 2'h2
`define SIB_SLICE_FWD_BONUS 2'h1

// ****************************************
// Address map
// ****************************************
`define SIB_TGT_BASE 32'h0000_0000
`define SIB_TGT_TOP 32'h7fff_ffff
`define SIB_SEC_BASE 32'h6000_0000
`define SIB_SEC_TOP 32'h7fff_ffff
`define SIB_GPV_BASE 32'hf000_0000
`define SIB_GPV_TOP 32'hf00f_ffff

// ****************************************
// Bus codes
// ****************************************
`define SIB_HTRANS_IDLE 2'h0
`define SIB_HTRANS_NONSEQ 2'h2
`define SIB_HTRANS_SEQ 2'h3
`define SIB_RESP_OKAY 2'h0
`define SIB_RESP_SLVERR 2'h2
`define SIB_RESP_DECERR 2'h3

`endif

// file: src/sib_pkg.sv
package sib_pkg;
	typedef enum logic [1:0] {SIB_SEC_NONSEC, SIB_SEC_SECURE, SIB_SEC_PERACC} sib_sec_t;
	typedef enum logic [2:0] {SIB_IDLE, SIB_DATA, SIB_ISSUE, SIB_WAIT, SIB_ERR1} sib_state_t;
	typedef enum logic [1:0] {SIB_SLICE_NONE, SIB_SLICE_FWD, SIB_SLICE_FULL} sib_slice_t;
	typedef enum logic [2:0] {SIB_CDC_ASYNC, SIB_CDC_1_1, SIB_CDC_1_N, SIB_CDC_N_1,
		SIB_CDC_N_M} sib_cdc_t;
endpackage

// file: src/sib_cnt_if.sv
`timescale 1ns/1ps
interface sib_cnt_if;
	logic inc;
	logic dec;
	logic [6:0] limit;
	logic [1:0] bonus;
	logic [7:0] count;
	logic full;
	modport ctl (output inc, dec, limit, bonus, input count, full);
	modport cnt (input inc, dec, limit, bonus, output count, full);
endinterface

// file: src/sib_acc_cnt.sv
`timescale 1ns/1ps
module sib_acc_cnt
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Counter port
	sib_cnt_if.cnt cif
);
	// ****************************************
	// Outstanding transaction count
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cif.count <= 8'h00;
		else if (cif.inc && !cif.dec)
			cif.count <= cif.count + 8'h01;
		else if (cif.dec && !cif.inc && cif.count != 8'h00)
			cif.count <= cif.count - 8'h01;
	end

	assign cif.full = cif.count >= ({1'b0, cif.limit} + {6'h00, cif.bonus});
endmodule

// file: bench/sib_net_model.sv
`timescale 1ns/1ps
module sib_net_model
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Pace
	input wire logic slow,
	// Requests
	input wire logic netReqValid,
	output logic netReqReady,
	input wire logic [31:0] netAddr,
	input wire logic netWrite,
	// Responses
	output logic netRspValid,
	output logic netRspWrite,
	output logic [31:0] netRspData,
	output logic [1:0] netRspResp
);
	logic [34:0] pend[$];
	logic [3:0] age;

	// ****************************************
	// In-order responder
	// ****************************************
	always @(posedge sys_clk)
	begin
		// whole words
		// Page five answers with a decode error
		if (netReqValid && netReqReady)
			pend.push_back({(netAddr[11:8] == 4'h5) ? 2'h3 : 2'h0, netWrite, ~netAddr});
		if (srst)
		begin
			pend.delete();
			netReqReady <= 1'b0;
			netRspValid <= 1'b0;
			netRspWrite <= 1'b0;
			netRspData <= 32'h0;
			netRspResp <= 2'h0;
			age <= 4'h0;
		end
		else
		begin
			netReqReady <= !slow || !netReqReady;
			if (pend.size() > 0 && age > (slow ? 4'h6 : 4'h1))
			begin
				netRspValid <= 1'b1;
				netRspWrite <= pend[0][32];
				netRspData <= pend[0][31:0];
				netRspResp <= pend[0][34:33];
				age <= 4'h0;
				void'(pend.pop_front());
			end
			else
			begin
				netRspValid <= 1'b0;
				netRspWrite <= !netRspWrite;
				netRspData <= ~netRspData;
				netRspResp <= ~netRspResp;
				age <= age + 4'h1;
			end
		end
	end
endmodule

// file: bench/sib_slave_interface_block_sva.sv
`timescale 1ns/1ps
`include "sib_cfg.svh"
module sib_chk
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Register bus
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Upstream
	input wire logic hsel,
	input wire logic hreadyIn,
	input wire logic [1:0] htrans,
	input wire logic hreadyOut,
	input wire logic hresp,
	// Network
	input wire logic netReqValid,
	input wire logic netReqReady,
	input wire logic [31:0] netAddr,
	input wire sib_pkg::sib_cdc_t cdcMode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_err_two;
		hresp && !hreadyOut |=> hresp && hreadyOut;
	endproperty
	a_err_two: assert property (p_err_two) else $error("error second cycle wrong");
	property p_err_start;
		$rose(hresp) |-> !hreadyOut;
	endproperty
	a_err_start: assert property (p_err_start) else $error("error first cycle wrong");
	property p_busy;
		hreadyOut && hsel && hreadyIn && htrans[1] |=> !hreadyOut;
	endproperty
	a_busy: assert property (p_busy) else $error("transfer not taken");
	property p_req_hold;
		netReqValid && !netReqReady |=> netReqValid && $stable(netAddr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request changed");
	property p_req_map;
		netReqValid |-> !(netAddr > `SIB_TGT_TOP
			&& (netAddr < `SIB_GPV_BASE || netAddr > `SIB_GPV_TOP));
	endproperty
	a_req_map: assert property (p_req_map) else $error("unmapped address sent");
	property p_cdc;
		$changed(cdcMode) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_cdc: assert property (p_cdc) else $error("crossing mode moved");

	c_err: cover property (hresp && hreadyOut);
	c_req: cover property (netReqValid && netReqReady);
	c_stall: cover property (netReqValid && !netReqReady);
endmodule

bind sib_slave_interface_block sib_chk i_sib_chk (.*);

// file: bench/tb_top.sv
`timescale 1ns/1ps
`include "sib_cfg.svh"
module tb_top;
	import sib_pkg::*;
	logic sys_clk, srst, slow, hsel, hreadyIn, hwrite, protNonsec;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hreadyOut, hresp;
	logic netReqValid, netReqReady, netWrite, netRspValid, netRspWrite;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, haddr, hwdata, hrdata;
	logic [31:0] netAddr, netWdata, netRspData, lastWdata;
	logic [3:0] s_axi_wstrb, hprot;
	logic [2:0] hsize, hburst, netSize, netProt, lastProt;
	logic [1:0] s_axi_bresp, s_axi_rresp, htrans, netRspResp;
	logic [7:0] huser, netUser, lastUser;
	sib_cdc_t cdcMode;
	int numErrors, cmpCount;

	sib_slave_interface_block i_sib_slave_interface_block (.*);
	sib_net_model i_sib_net_model (.*);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
		if (netReqValid && netReqReady)
		begin
			lastProt <= netProt;
			lastWdata <= netWdata;
			lastUser <= netUser;
		end

	task results;
		$display("checks %0d mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			numErrors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task bound(inout int n);
		n++;
		if (n > 200)
		begin
			numErrors++;
			$display("[FAIL] %0t no answer", $time);
			results();
		end
	endtask

	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, wd;
		int n;
		ad = 1'b0;
		wd = 1'b0;
		n = 0;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(negedge sys_clk);
			ad = ad || s_axi_awready;
			wd = wd || s_axi_wready;
			@(posedge sys_clk);
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !wd;
			bound(n);
		end
		do
		begin
			@(negedge sys_clk);
			bound(n);
		end while (s_axi_bvalid !== 1'b1);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge sys_clk);
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge sys_clk);
			bound(n);
		end while (s_axi_arready !== 1'b1);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(negedge sys_clk);
			bound(n);
		end while (s_axi_rvalid !== 1'b1);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		if (er === `SIB_RESP_OKAY)
			chk(s_axi_rdata, ed);
		@(posedge sys_clk);
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task ahb(input logic [31:0] a, input logic wr, input logic [3:0] p, input logic ns,
		input logic ee);
		int n;
		n = 0;
		haddr <= a;
		hwrite <= wr;
		hprot <= p;
		protNonsec <= ns;
		huser <= a[7:0];
		htrans <= `SIB_HTRANS_NONSEQ;
		@(posedge sys_clk);
		htrans <= `SIB_HTRANS_IDLE;
		hwdata <= ~a;
		do
		begin
			@(negedge sys_clk);
			bound(n);
		end while (hreadyOut !== 1'b1);
		chk({31'h0, hresp}, {31'h0, ee});
		if (!wr && !ee && !a[31])
			chk(hrdata, ~a);
		@(posedge sys_clk);
	endtask

	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, haddr, hwdata} = '0;
		{hwrite, protNonsec, slow, hprot, htrans, huser} = '0;
		s_axi_wstrb = 4'hf;
		hsize = 3'h2;
		hburst = 3'h0;
		hsel = 1'b1;
		hreadyIn = 1'b1;
		srst = 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		axi_rd(8'h00, 32'h0, `SIB_RESP_OKAY);
		axi_rd(8'h04, 32'h0000_7f20, `SIB_RESP_OKAY);
		axi_rd(8'h10, 32'h0, `SIB_RESP_SLVERR);
		axi_wr(8'h08, 32'h0, `SIB_RESP_SLVERR);
		axi_wr(8'h04, 32'h0, `SIB_RESP_OKAY);
		axi_rd(8'h04, 32'h0000_0101, `SIB_RESP_OKAY);
		axi_wr(8'h04, 32'h0000_ff3f, `SIB_RESP_OKAY);
		axi_rd(8'h04, 32'h0000_7f20, `SIB_RESP_OKAY);
		$display("test registers done");
		for (int i = 0; i < 5; i++)
		begin
			axi_wr(8'h00, {24'h0, 3'(i), 3'h0, 2'(i % 3)}, `SIB_RESP_OKAY);
			chk({29'h0, cdcMode}, 32'(i));
			ahb(32'h6000_0010, 1'b0, 4'h3, i != 2, i % 3 == 0);
			if (i % 3 != 0)
				chk({31'h0, lastProt[1]}, 32'h0);
			ahb(32'h0000_0100, 1'b0, 4'h3, 1'b1, 1'b0);
			chk({31'h0, lastProt[1]}, 32'(i % 3 != 1));
		end
		$display("test security done");
		axi_wr(8'h00, 32'h0, `SIB_RESP_OKAY);
		ahb(32'h8000_0000, 1'b0, 4'h3, 1'b0, 1'b1);
		ahb(32'hf000_0000, 1'b0, 4'h3, 1'b0, 1'b0);
		ahb(32'h0000_0500, 1'b0, 4'h3, 1'b0, 1'b1);
		axi_wr(8'h00, 32'h8, `SIB_RESP_OKAY);
		hburst <= 3'h3;
		ahb(32'h8000_0000, 1'b0, 4'h3, 1'b0, 1'b0);
		hburst <= 3'h0;
		axi_rd(8'h0c, 32'h0001_0005, `SIB_RESP_OKAY);
		axi_wr(8'h00, 32'h4, `SIB_RESP_OKAY);
		ahb(32'h8000_0000, 1'b1, 4'hb, 1'b0, 1'b0);
		ahb(32'h8000_0000, 1'b1, 4'h3, 1'b0, 1'b1);
		ahb(32'h0000_0500, 1'b1, 4'hb, 1'b0, 1'b0);
		chk(lastWdata, ~32'h500);
		ahb(32'h0000_0500, 1'b1, 4'h3, 1'b0, 1'b1);
		$display("test errors done");
		axi_wr(8'h00, 32'h0, `SIB_RESP_OKAY);
		slow <= 1'b1;
		ahb(32'h0000_0300, 1'b1, 4'h3, 1'b0, 1'b0);
		chk(lastWdata, ~32'h300);
		ahb(32'h0000_0304, 1'b0, 4'h3, 1'b0, 1'b0);
		chk({24'h0, lastUser}, 32'h0000_0004);
		slow <= 1'b0;
		hsel <= 1'b0;
		htrans <= `SIB_HTRANS_NONSEQ;
		@(posedge sys_clk);
		htrans <= `SIB_HTRANS_IDLE;
		@(negedge sys_clk);
		chk({31'h0, hreadyOut}, 32'h1);
		@(posedge sys_clk);
		axi_wr(8'h00, 32'h18, `SIB_RESP_OKAY);
		axi_rd(8'h00, 32'h10, `SIB_RESP_OKAY);
		ahb(32'h0000_0400, 1'b0, 4'h3, 1'b0, 1'b0);
		hsel <= 1'b1;
		axi_rd(8'h08, 32'h0001_0000, `SIB_RESP_OKAY);
		$display("test variants done");
		results();
	end
endmodule
